// *** core/reverse_power_pkg.sv ***
/*
   Constants and types for the reverse power protection stage.
   Assumes a 100 MHz clock and a 32-bit Avalon-MM register slave.
*/
package reverse_power_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ          = 100;
   localparam int TICK_MS          = 1;
   localparam int TICK_CYCLES      = TICK_MS * 1000 * CLK_MHZ;
   localparam int SAMPLE_MS        = 5;
   localparam int AVG_MS           = 20;
   localparam int AVG_SAMPLES      = AVG_MS / SAMPLE_MS;
   localparam int RESET_PCT        = 97;
   localparam int NUM_GROUPS       = 8;
   localparam int LOG_DEPTH        = 12;
   // ==========================================================
   // Register word offsets (byte address = index * 4)
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_GROUP_SEL = 8'h01;
   localparam logic [7:0] REG_STATUS    = 8'h02;
   localparam logic [7:0] REG_RATIO     = 8'h03;
   localparam logic [7:0] REG_REMAIN    = 8'h04;
   localparam logic [7:0] REG_CNT_START = 8'h05;
   localparam logic [7:0] REG_CNT_TRIP  = 8'h06;
   localparam logic [7:0] REG_CNT_BLK   = 8'h07;
   localparam logic [7:0] REG_CNT_CLR   = 8'h08;
   localparam logic [7:0] REG_AVG_PWR   = 8'h09;
   localparam logic [7:0] REG_LOG_IDX   = 8'h0a;
   localparam logic [7:0] REG_LOG_BASE  = 8'h10;
   localparam logic [7:0] REG_GRP_BASE  = 8'h40;
   // Group block: pick-up, delay, mode at index base + 4*g + field
   localparam logic [7:0] GRP_PICKUP    = 8'h00;
   localparam logic [7:0] GRP_DELAY     = 8'h01;
   localparam logic [7:0] GRP_MODE      = 8'h02;
   // ==========================================================
   // Control fields
   localparam int CTRL_FORCE_EN    = 0;
   localparam int CTRL_FORCE_LSB   = 1;
   localparam int CTRL_SIDE        = 3;
   localparam int CTRL_EVT_ON      = 4;
   localparam int CTRL_EVT_OFF     = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
   localparam logic [31:0] PICKUP_RESET = 32'h0000_2710; // 100.00 kW
   localparam logic [31:0] DELAY_RESET  = 32'h0000_0014; // 5 ms steps
   typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} cond_t;
   typedef enum logic [2:0] {EV_START_ON, EV_START_OFF, EV_TRIP_ON, EV_TRIP_OFF,
                             EV_BLOCK_ON, EV_BLOCK_OFF} event_t;
endpackage

// *** core/reverse_power_stage.sv ***
/*
   Single reverse power protection stage with register slave, event port
   and twelve-entry ON log. Assumes power samples (0.01 kW units, reverse
   direction positive) arrive as same-clock pulses every 5 ms.
*/
`timescale 1ns/10ps
module reverse_power_stage
   import reverse_power_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [31:0] power_a_i,
   input  wire logic [31:0] power_b_i,
   input  wire logic        sample_valid_i,
   input  wire logic        block_i,
   input  wire logic        force_global_i,
   output logic             start_o,
   output logic             trip_o,
   output logic             blocked_o,
   output logic             event_valid_o,
   output logic [2:0]       event_code_o,
   output logic [31:0]      event_time_o,
   output logic [31:0]      event_power_o
);
   // ==========================================================
   // Registers
   logic [31:0] ctrl_q;
   logic [2:0]  group_sel_q;
   logic [31:0] pickup_q [NUM_GROUPS];
   logic [31:0] delay_q  [NUM_GROUPS];
   logic        instant_q[NUM_GROUPS];
   logic [31:0] cnt_start_q, cnt_trip_q, cnt_blk_q;
   logic [31:0] ms_q, tick_q;
   logic        blk_s1_q, blk_s2_q, force_s1_q, force_s2_q;
   logic        picked_q, start_q, trip_q, blocked_q;
   logic [31:0] elapsed_q, startup_pwr_q, ratio_q;
   logic [31:0] avg_buf_q [AVG_SAMPLES];
   logic [31:0] avg_q;
   logic [31:0] log_time_q [LOG_DEPTH];
   logic [2:0]  log_evt_q  [LOG_DEPTH];
   logic [31:0] log_pre_q  [LOG_DEPTH];
   logic [31:0] log_flt_q  [LOG_DEPTH];
   logic [31:0] log_rem_q  [LOG_DEPTH];
   logic [2:0]  log_grp_q  [LOG_DEPTH];
   logic [3:0]  log_wr_q, log_rd_q;
   logic        rd_pend_q;
   logic [31:0] rdata_q;

   function automatic logic [31:0] pct_of(input logic [31:0] v);
      pct_of = 32'((64'(v) * 64'(RESET_PCT)) / 64'd100);
   endfunction

   // ==========================================================
   // Inputs and time base
   // Block and forcing come from pins, so each passes two flops first
   always_ff @(posedge clk_i) begin
      blk_s1_q   <= block_i;
      blk_s2_q   <= blk_s1_q;
      force_s1_q <= force_global_i;
      force_s2_q <= force_s1_q;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tick_q <= 32'h0;
         ms_q   <= 32'h0;
      end else if (tick_q == 32'(TICK_CYCLES - 1)) begin
         tick_q <= 32'h0;
         ms_q   <= ms_q + 32'h1;
      end else begin
         tick_q <= tick_q + 32'h1;
      end
   end

   // ==========================================================
   // Measurement
   // Inputs are stale between sample pulses; nothing here latches them then
   logic [31:0] pwr;
   logic [31:0] pset, dly;
   logic        inst;
   logic [33:0] avg_sum;
   assign pwr  = ctrl_q[CTRL_SIDE] ? power_b_i : power_a_i;
   assign pset = pickup_q[group_sel_q];
   assign dly  = delay_q[group_sel_q];
   assign inst = instant_q[group_sel_q];

   always_comb begin
      avg_sum = 34'(pwr);
      for (int i = 0; i < AVG_SAMPLES - 1; i++) avg_sum = avg_sum + 34'(avg_buf_q[i]);
   end

   // Four 5 ms samples make 20 ms; the newest is added live to save a register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < AVG_SAMPLES; i++) avg_buf_q[i] <= 32'h0;
         avg_q <= 32'h0;
      end else if (sample_valid_i) begin
         avg_buf_q[0] <= pwr;
         for (int i = 1; i < AVG_SAMPLES; i++) avg_buf_q[i] <= avg_buf_q[i-1];
         avg_q <= 32'(avg_sum / 34'(AVG_SAMPLES));
      end
   end

   // ==========================================================
   // Protection logic, evaluated once per sample
   // Hysteresis: once picked up, hold on until power falls below 97 percent
   logic pick_now;
   always_comb begin
      if (picked_q) pick_now = pwr >= pct_of(pset);
      else pick_now = pwr >= pset;
   end

   // The synchronised block level is read before pick-up picks start or blocked
   logic start_d, trip_d, blocked_d;
   always_comb begin
      blocked_d = pick_now && blk_s2_q;
      start_d   = pick_now && !blk_s2_q;
      trip_d    = start_d && (inst || elapsed_q + 32'h1 >= dly);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         picked_q       <= 1'b0;
         start_q        <= 1'b0;
         trip_q         <= 1'b0;
         blocked_q      <= 1'b0;
         elapsed_q      <= 32'h0;
         ratio_q        <= 32'h0;
         startup_pwr_q  <= 32'h0;
      end else if (sample_valid_i) begin
         picked_q       <= pick_now;
         start_q        <= start_d;
         trip_q         <= trip_d;
         blocked_q      <= blocked_d;
         elapsed_q      <= start_d ? elapsed_q + 32'h1 : 32'h0;
         ratio_q        <= (pset == 32'h0) ? 32'hffff_ffff : 32'((64'(pwr) * 64'd100) / 64'(pset));
         if (pick_now && !picked_q) startup_pwr_q <= pwr;
      end
   end

   // ==========================================================
   // Outputs with forcing
   cond_t cond;
   always_comb begin
      if (force_s2_q && ctrl_q[CTRL_FORCE_EN]) cond = cond_t'(ctrl_q[CTRL_FORCE_LSB +: 2]);
      else if (blocked_q) cond = COND_BLOCKED;
      else if (trip_q) cond = COND_TRIP;
      else if (start_q) cond = COND_START;
      else cond = COND_NORMAL;
   end
   // Forced trip also shows start so the output pattern matches a real trip
   assign start_o   = (cond == COND_START) || (cond == COND_TRIP);
   assign trip_o    = (cond == COND_TRIP);
   assign blocked_o = (cond == COND_BLOCKED);

   // ==========================================================
   // Events: one per cycle, priority start, trip, blocked
   logic st_p_q, tr_p_q, bl_p_q;
   logic st_pend_q, tr_pend_q, bl_pend_q, st_on_q, tr_on_q, bl_on_q;
   logic ev_ok;
   event_t ev_code;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_p_q <= 1'b0;
         tr_p_q <= 1'b0;
         bl_p_q <= 1'b0;
      end else begin
         st_p_q <= start_o;
         tr_p_q <= trip_o;
         bl_p_q <= blocked_o;
      end
   end

   always_comb begin
      ev_ok   = 1'b0;
      ev_code = EV_START_ON;
      if (st_pend_q) begin
         ev_ok   = 1'b1;
         ev_code = st_on_q ? EV_START_ON : EV_START_OFF;
      end else if (tr_pend_q) begin
         ev_ok   = 1'b1;
         ev_code = tr_on_q ? EV_TRIP_ON : EV_TRIP_OFF;
      end else if (bl_pend_q) begin
         ev_ok   = 1'b1;
         ev_code = bl_on_q ? EV_BLOCK_ON : EV_BLOCK_OFF;
      end
   end

   logic [31:0] ev_time_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         {st_pend_q, tr_pend_q, bl_pend_q, st_on_q, tr_on_q, bl_on_q} <= 6'h0;
      end else begin
         // New edges win over the clear of a pending flag
         if (start_o != st_p_q) begin
            st_pend_q <= 1'b1;
            st_on_q   <= start_o;
         end else if (ev_ok && ev_code inside {EV_START_ON, EV_START_OFF}) st_pend_q <= 1'b0;
         if (trip_o != tr_p_q) begin
            tr_pend_q <= 1'b1;
            tr_on_q   <= trip_o;
         end else if (ev_ok && ev_code inside {EV_TRIP_ON, EV_TRIP_OFF}) tr_pend_q <= 1'b0;
         if (blocked_o != bl_p_q) begin
            bl_pend_q <= 1'b1;
            bl_on_q   <= blocked_o;
         end else if (ev_ok && ev_code inside {EV_BLOCK_ON, EV_BLOCK_OFF}) bl_pend_q <= 1'b0;
      end
   end

   // One stamp per cycle of edges, so an instant start and trip share it; an
   // edge that comes before the queue drains restamps what is still pending
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ev_time_q <= 32'h0;
      end else if (start_o != st_p_q || trip_o != tr_p_q || blocked_o != bl_p_q) begin
         ev_time_q <= ms_q;
      end
   end

   logic ev_is_on, ev_keep;
   assign ev_is_on = !ev_code[0];
   assign ev_keep  = ev_is_on ? ctrl_q[CTRL_EVT_ON] : ctrl_q[CTRL_EVT_OFF];

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         event_valid_o <= 1'b0;
         event_code_o  <= 3'h0;
         event_time_o  <= 32'h0;
         event_power_o <= 32'h0;
      end else begin
         event_valid_o <= ev_ok && ev_keep;
         event_code_o  <= ev_code;
         event_time_o  <= ev_time_q;
         event_power_o <= startup_pwr_q;
      end
   end

   // ==========================================================
   // Counters and log
   // Remaining time in 5 ms samples; zero in instant mode
   logic [31:0] remain;
   assign remain = inst ? 32'h0 : 32'(dly - elapsed_q);

   // A clear wins over a count in the same cycle; software clears on purpose
   logic clr_cnt;
   assign clr_cnt = avs_write_i && avs_address_i == REG_CNT_CLR;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || clr_cnt) begin
         cnt_start_q <= 32'h0;
         cnt_trip_q  <= 32'h0;
         cnt_blk_q   <= 32'h0;
      end else begin
         if (start_o && !st_p_q) cnt_start_q <= cnt_start_q + 32'h1;
         if (trip_o && !tr_p_q) cnt_trip_q <= cnt_trip_q + 32'h1;
         if (blocked_o && !bl_p_q) cnt_blk_q <= cnt_blk_q + 32'h1;
      end
   end

   // Every ON record is logged, whatever the event filter lets out
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         log_wr_q <= 4'h0;
      end else if (ev_ok && ev_is_on) begin
         log_time_q[log_wr_q] <= ms_q;
         log_evt_q[log_wr_q]  <= ev_code;
         log_pre_q[log_wr_q]  <= avg_q;
         log_flt_q[log_wr_q]  <= startup_pwr_q;
         log_rem_q[log_wr_q]  <= remain;
         log_grp_q[log_wr_q]  <= group_sel_q;
         log_wr_q <= (log_wr_q == 4'(LOG_DEPTH - 1)) ? 4'h0 : log_wr_q + 4'h1;
      end
   end

   // ==========================================================
   // Avalon-MM slave: writes in one cycle, reads after one wait
   // The wait lets read data come straight from a register
   logic [7:0] goff;
   logic [2:0] gsel;
   assign goff = avs_address_i - REG_GRP_BASE;
   assign gsel = goff[4:2];

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_q      <= CTRL_RESET;
         group_sel_q <= 3'h0;
         log_rd_q    <= 4'h0;
         for (int g = 0; g < NUM_GROUPS; g++) begin
            pickup_q[g]  <= PICKUP_RESET;
            delay_q[g]   <= DELAY_RESET;
            instant_q[g] <= 1'b0;
         end
      end else if (avs_write_i) begin
         if (avs_address_i == REG_CTRL) ctrl_q <= avs_writedata_i;
         if (avs_address_i == REG_GROUP_SEL) group_sel_q <= avs_writedata_i[2:0];
         if (avs_address_i == REG_LOG_IDX && avs_writedata_i[3:0] < 4'(LOG_DEPTH)) log_rd_q <= avs_writedata_i[3:0];
         if (avs_address_i >= REG_GRP_BASE && avs_address_i < REG_GRP_BASE + 8'h20) begin
            if (goff[1:0] == GRP_PICKUP[1:0]) pickup_q[gsel] <= avs_writedata_i;
            if (goff[1:0] == GRP_DELAY[1:0]) delay_q[gsel] <= avs_writedata_i;
            if (goff[1:0] == GRP_MODE[1:0]) instant_q[gsel] <= avs_writedata_i[0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_pend_q <= 1'b0;
         rdata_q   <= 32'h0;
      end else begin
         rd_pend_q <= avs_read_i && !rd_pend_q;
         case (avs_address_i)
            REG_CTRL:           rdata_q <= ctrl_q;
            REG_GROUP_SEL:      rdata_q <= {29'h0, group_sel_q};
            REG_STATUS:         rdata_q <= {30'h0, cond};
            REG_RATIO:          rdata_q <= ratio_q;
            REG_REMAIN:         rdata_q <= remain;
            REG_CNT_START:      rdata_q <= cnt_start_q;
            REG_CNT_TRIP:       rdata_q <= cnt_trip_q;
            REG_CNT_BLK:        rdata_q <= cnt_blk_q;
            REG_AVG_PWR:        rdata_q <= avg_q;
            REG_LOG_IDX:        rdata_q <= {24'h0, log_wr_q, log_rd_q};
            REG_LOG_BASE:       rdata_q <= log_time_q[log_rd_q];
            REG_LOG_BASE+8'h01: rdata_q <= {29'h0, log_evt_q[log_rd_q]};
            REG_LOG_BASE+8'h02: rdata_q <= log_pre_q[log_rd_q];
            REG_LOG_BASE+8'h03: rdata_q <= log_flt_q[log_rd_q];
            REG_LOG_BASE+8'h04: rdata_q <= log_rem_q[log_rd_q];
            REG_LOG_BASE+8'h05: rdata_q <= {29'h0, log_grp_q[log_rd_q]};
            default: begin
               if (avs_address_i >= REG_GRP_BASE && avs_address_i < REG_GRP_BASE + 8'h20) begin
                  case (goff[1:0])
                     GRP_PICKUP[1:0]: rdata_q <= pickup_q[gsel];
                     GRP_DELAY[1:0]:  rdata_q <= delay_q[gsel];
                     GRP_MODE[1:0]:   rdata_q <= {31'h0, instant_q[gsel]};
                     default:         rdata_q <= 32'h0;
                  endcase
               end else rdata_q <= 32'h0;
            end
         endcase
      end
   end

   assign avs_waitrequest_o = avs_read_i && !rd_pend_q;
   assign avs_readdata_o    = rdata_q;
endmodule // reverse_power_stage

// *** sim/power_meas_model.sv ***
/*
   Measurement pre-processor and blocking matrix model.
   Assumes the bench sets the wanted power and block level between samples.
*/
`timescale 1ns/10ps
module power_meas_model #(
   parameter int GAP = 16
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [31:0] set_a_i,
   input  wire logic [31:0] set_b_i,
   input  wire logic        set_block_i,
   output logic      [31:0] power_a_o,
   output logic      [31:0] power_b_o,
   output logic             sample_valid_o,
   output logic             block_o
);
   logic [15:0] cnt_q;
   logic [31:0] a_q;
   logic [31:0] b_q;
   // ==========================================================
   // Sample beat: 5 ms in the relay, shortened so the run stays brief
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_q <= 16'h0;
         sample_valid_o <= 1'b0;
         block_o <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == 16'(GAP - 1)) ? 16'h0 : cnt_q + 16'h1;
         sample_valid_o <= (cnt_q == 16'h0);
         if (cnt_q == 16'h0) begin
            a_q <= set_a_i;
            b_q <= set_b_i;
            block_o <= set_block_i;
         end
      end
   end
   // Between samples the values are stale, so show garbage there
   assign power_a_o = sample_valid_o ? a_q : ~a_q;
   assign power_b_o = sample_valid_o ? b_q : ~b_q;
endmodule // power_meas_model

// *** sim/reverse_power_stage_chk.sv ***
/*
   Concurrent checks on the ports of the reverse power stage.
   Assumes one clock domain and the event filter held in CTRL bits 5:4.
*/
`timescale 1ns/10ps
module reverse_power_stage_chk
   import reverse_power_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic [7:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [31:0] power_a_i,
   input wire logic [31:0] power_b_i,
   input wire logic        sample_valid_i,
   input wire logic        block_i,
   input wire logic        force_global_i,
   input wire logic        start_o,
   input wire logic        trip_o,
   input wire logic        blocked_o,
   input wire logic        event_valid_o,
   input wire logic [2:0]  event_code_o,
   input wire logic [31:0] event_time_o,
   input wire logic [31:0] event_power_o
);
   // ==========================================================
   // Shadow of the event filter, since the checker cannot see CTRL
   logic [1:0]  filt_q;
   logic [31:0] last_time_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         filt_q <= 2'b11;
      end else if (avs_write_i && avs_address_i == REG_CTRL) begin
         filt_q <= avs_writedata_i[CTRL_EVT_OFF:CTRL_EVT_ON];
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         last_time_q <= 32'h0;
      end else if (event_valid_o) begin
         last_time_q <= event_time_o;
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   rd_wait_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read answer not in second cycle");
   wr_wait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
      else $error("write was stalled");
   rst_out_a: assert property ($fell(sys_rst_i) |-> !start_o && !trip_o && !blocked_o && !event_valid_o)
      else $error("outputs active after reset");
   trip_start_a: assert property (trip_o |-> start_o)
      else $error("trip without start");
   blk_start_a: assert property (blocked_o |-> !start_o)
      else $error("start while blocked");
   start_on_a: assert property ($rose(start_o) && filt_q[0] |-> ##[1:6] (event_valid_o && event_code_o == EV_START_ON))
      else $error("no start on event");
   start_off_a: assert property ($fell(start_o) && filt_q[1] |-> ##[1:6] (event_valid_o && event_code_o == EV_START_OFF))
      else $error("no start off event");
   blk_on_a: assert property ($rose(blocked_o) && filt_q[0] |-> ##[1:6] (event_valid_o && event_code_o == EV_BLOCK_ON))
      else $error("no block on event");
   same_stamp_a: assert property (event_valid_o && event_code_o == EV_START_ON ##1 event_valid_o && event_code_o == EV_TRIP_ON |-> event_time_o == $past(event_time_o))
      else $error("start and trip stamps differ");
   time_order_a: assert property (event_valid_o |-> event_time_o >= last_time_q)
      else $error("event time went back");
endmodule // reverse_power_stage_chk

bind reverse_power_stage reverse_power_stage_chk u_reverse_power_stage_chk (.clk_i, .sys_rst_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .power_a_i, .power_b_i,
   .sample_valid_i, .block_i, .force_global_i, .start_o, .trip_o, .blocked_o, .event_valid_o, .event_code_o,
   .event_time_o, .event_power_o);

// *** sim/reverse_power_stage_tb.sv ***
/*
   Self-checking bench for the reverse power stage.
   Assumes the checker is bound in and the model beats every 16 cycles.
*/
`timescale 1ns/10ps
module reverse_power_stage_tb;
   import reverse_power_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst, avs_read, avs_write, force_global, set_blk;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, power_a, power_b, set_a, set_b, rdat;
   logic        avs_waitrequest, sample_valid, block, start, trip, blocked;
   logic        ev_valid;
   logic [2:0]  ev_code, last_code;
   logic [31:0] ev_time, ev_power, last_time, last_power;
   int          n_fail = 0;
   int          checked = 0;
   int          cyc = 0;
   always #5 clk = ~clk;
   reverse_power_stage u_reverse_power_stage (.clk_i(clk), .sys_rst_i(sys_rst), .avs_address_i(avs_address),
      .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
      .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .power_a_i(power_a),
      .power_b_i(power_b), .sample_valid_i(sample_valid), .block_i(block), .force_global_i(force_global),
      .start_o(start), .trip_o(trip), .blocked_o(blocked), .event_valid_o(ev_valid), .event_code_o(ev_code),
      .event_time_o(ev_time), .event_power_o(ev_power));
   power_meas_model u_power_meas_model (.clk_i(clk), .sys_rst_i(sys_rst), .set_a_i(set_a), .set_b_i(set_b),
      .set_block_i(set_blk), .power_a_o(power_a), .power_b_o(power_b), .sample_valid_o(sample_valid),
      .block_o(block));
   // Last event seen on the event port
   always @(posedge clk) begin
      if (ev_valid === 1'b1) begin
         last_code  <= ev_code;
         last_time  <= ev_time;
         last_power <= ev_power;
      end
   end
   // ==========================================================
   // Reporting
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   // ==========================================================
   // Avalon-MM master: hold until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, rdat, exp);
   endtask
   task automatic samp(input int k);
      int s;
      s = 0;
      // Skip a beat launched at the same edge as the new stimulus
      @(posedge clk);
      while (s < k) begin
         @(negedge clk);
         if (sample_valid === 1'b1) s++;
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic outs(input logic [2:0] e);
      chk("outputs", {29'h0, blocked, trip, start}, {29'h0, e});
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      {sys_rst, avs_read, avs_write, force_global, set_blk} = 5'b10000;
      {avs_address, avs_writedata, set_a, set_b} = '0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd("ctrl", REG_CTRL, CTRL_RESET);
      for (int g = 0; g < NUM_GROUPS; g++) begin
         rd("pickup", REG_GRP_BASE + 8'(4 * g) + GRP_PICKUP, PICKUP_RESET);
         rd("delay", REG_GRP_BASE + 8'(4 * g) + GRP_DELAY, DELAY_RESET);
      end
      bus(1'b1, 8'h30, 32'hffff_ffff);
      rd("unmapped", 8'h30, 32'h0);
      bus(1'b1, REG_GRP_BASE + 8'h04 + GRP_PICKUP, 32'h0000_03e8);
      bus(1'b1, REG_GRP_BASE + 8'h04 + GRP_DELAY, 32'h0000_0003);
      bus(1'b1, REG_GROUP_SEL, 32'h1);
      set_a <= 32'h0000_03e7;
      samp(2);
      outs(3'b000);
      set_a <= 32'h0000_03e8;
      samp(1);
      outs(3'b001);
      samp(1);
      outs(3'b001);
      samp(1);
      outs(3'b011);
      samp(1);
      outs(3'b011);
      rd("condition", REG_STATUS, 32'h2);
      rd("average", REG_AVG_PWR, 32'h0000_03e8);
      rd("ratio", REG_RATIO, 32'h0000_0064);
      set_a <= 32'h0000_03ca;
      samp(1);
      outs(3'b011);
      set_a <= 32'h0000_03c9;
      samp(1);
      outs(3'b000);
      rd("start count", REG_CNT_START, 32'h1);
      rd("trip count", REG_CNT_TRIP, 32'h1);
      bus(1'b1, REG_CNT_CLR, 32'h1);
      rd("start count", REG_CNT_START, 32'h0);
      bus(1'b1, REG_CTRL, CTRL_RESET | 32'h8);
      set_b <= 32'h0000_05dc;
      samp(1);
      outs(3'b001);
      rd("ratio", REG_RATIO, 32'h0000_0096);
      set_b <= 32'h0;
      samp(1);
      bus(1'b1, REG_CTRL, CTRL_RESET);
      bus(1'b1, REG_GRP_BASE + 8'h04 + GRP_DELAY, 32'h0000_0008);
      set_blk <= 1'b1;
      samp(2);
      set_a <= 32'h0000_03e8;
      samp(1);
      outs(3'b100);
      rd("condition", REG_STATUS, 32'h3);
      rd("block count", REG_CNT_BLK, 32'h1);
      chk("block event", {29'h0, last_code}, 32'(EV_BLOCK_ON));
      chk("block power", last_power, 32'h0000_03e8);
      chk("block time", last_time, 32'h0);
      rd("log index", REG_LOG_IDX, 32'h0000_0040);
      bus(1'b1, REG_LOG_IDX, 32'h3);
      rd("log event", REG_LOG_BASE + 8'h01, 32'(EV_BLOCK_ON));
      rd("log fault", REG_LOG_BASE + 8'h03, 32'h0000_03e8);
      set_blk <= 1'b0;
      samp(2);
      outs(3'b001);
      set_blk <= 1'b1;
      samp(2);
      outs(3'b100);
      set_blk <= 1'b0;
      set_a <= 32'h0;
      samp(2);
      outs(3'b000);
      bus(1'b1, REG_GRP_BASE + 8'h04 + GRP_MODE, 32'h1);
      set_a <= 32'h0000_03e8;
      samp(1);
      outs(3'b011);
      set_a <= 32'h0;
      samp(1);
      outs(3'b000);
      force_global <= 1'b1;
      for (int c = 1; c < 4; c++) begin
         bus(1'b1, REG_CTRL, CTRL_RESET | 32'(c << CTRL_FORCE_LSB) | 32'h1);
         samp(1);
         rd("forced", REG_STATUS, 32'(c));
         outs((c == 1) ? 3'b001 : (c == 2) ? 3'b011 : 3'b100);
      end
      force_global <= 1'b0;
      bus(1'b1, REG_CTRL, CTRL_RESET | 32'h5);
      samp(1);
      outs(3'b000);
      final_report();
   end
endmodule // reverse_power_stage_tb
